// [hw/irq_ctrl_pkg.sv]
// Constants of the interrupt and reset control block: RAM bit locations, vectors, reset values.
// Assumes the core reaches the control bits through a nibble-wide RAM bit port.
// What this block does
// - Seven sources, fixed priority 1..7, vectors 0x0002 to 0x000E in steps of two.
// - Reset and stop-cancel vector to zero; stop-cancel counts only in stop mode.
// - Take a source when enabled, flagged, unmasked, and no higher unmasked source pending.
// - Lower-priority flags and masks never change the issued vector.
// - Global enable at 0x000 bit 0; cleared on taking, set on return.
// - External flags set on rising edge of their inputs; 1 means pending.
// - External masks at 0x000 bit 3 and 0x001 bit 1; 1 blocks.
// - Stop-cancel keeps port B mode bit 3 and sets RAM-valid; other resets clear both.
// - Reset clears enable and flags, sets every mask.
// - Software writes can clear a flag but never set it.
// - After acknowledge: finish instruction, clear enable in cycle two, jump in cycle three.
package irq_ctrl_pkg;
  // ==========================================================================
  // Control word locations and bit positions
  localparam logic [1:0] ADDR_WORD0 = 2'h0;
  localparam logic [1:0] ADDR_WORD1 = 2'h1;
  localparam logic [1:0] ADDR_WORD2 = 2'h2;
  localparam logic [1:0] ADDR_WORD3 = 2'h3;
  localparam int NUM_SRC = 7;
  // Source order: 0 ext0, 1 ext1, 2 timer A, 3 timer B, 4 timer C, 5 A/D, 6 serial.
  // Flag and mask bit positions per source, word index then bit.
  localparam logic [1:0] FLAG_WORD [NUM_SRC] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  localparam int         FLAG_BIT  [NUM_SRC] = '{2, 0, 2, 0, 2, 0, 2};
  localparam int         MASK_BIT  [NUM_SRC] = '{3, 1, 3, 1, 3, 1, 3};
  localparam int         IE_BIT = 0;
  // ==========================================================================
  // Vectors and reset values
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE  = 16'h0002;
  localparam logic [15:0] VEC_STEP  = 16'h0002;
  localparam logic [NUM_SRC-1:0] FLAG_RESET = 7'h00;
  localparam logic [NUM_SRC-1:0] MASK_RESET = 7'h7F;
  localparam logic IE_RESET = 1'b0;
  // Cycles of the acknowledge sequence.
  localparam int ACK_CYCLES = 3;
endpackage

// [hw/ext_edge_sync.sv]
// Two-flop synchroniser with rising-edge pulse for one external interrupt pin.
// Assumes the pin level is asynchronous to core_clk; the rise is seen one to two cycles late.
`timescale 1ns/1ps
`default_nettype none
module ext_edge_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Pin and event
  input  wire logic pin_level,
  output logic      rise_pulse
);
  logic meta;
  logic sync;
  logic prev;
  // ==========================================================================
  // Synchroniser
  // Only the second and third stages are looked at, so no logic reads a metastable value.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin_level;
      sync <= meta;
      prev <= sync;
    end
  end
  assign rise_pulse = sync & ~prev;
endmodule
`default_nettype wire

// [hw/interrupt_reset_control.sv]
// Interrupt arbitration, control bits and stop-cancel entry of the small 4-bit core.
// Assumes the core drives a one-cycle bit-port write, instruction-boundary and return strobes.
`timescale 1ns/1ps
`default_nettype none
module interrupt_reset_control
  import irq_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // External pins
  input  wire logic        ext_irq_in0,
  input  wire logic        ext_irq_in1,
  input  wire logic        stop_cancel_in,
  // Internal request events, one-cycle pulses
  input  wire logic        timer_a_event,
  input  wire logic        timer_b_event,
  input  wire logic        timer_c_event,
  input  wire logic        conv_done_event,
  input  wire logic        shift_done_event,
  // Control-bit port from the core
  input  wire logic [1:0]  ctl_addr,
  input  wire logic        ctl_wr,
  input  wire logic [3:0]  ctl_wdata,
  output logic      [3:0]  ctl_rdata,
  // Core sequencer
  input  wire logic        instr_boundary,
  input  wire logic        return_from_irq_instr,
  input  wire logic        stop_mode,
  input  wire logic        portb_mode_bit3_wr,
  input  wire logic        portb_mode_bit3_wdata,
  output logic             irq_ack,
  output logic             irq_push,
  output logic             irq_jump,
  output logic      [15:0] irq_vector,
  output logic             stop_cancel_req,
  output logic             ram_valid_flag,
  output logic             portb_mode_bit3
);
  typedef enum logic [1:0] {S_IDLE, S_FINISH, S_SAVE, S_JUMP} seq_e;
  seq_e seq;
  seq_e next_seq;

  logic                global_irq_enable;
  logic [NUM_SRC-1:0]  flag;
  logic [NUM_SRC-1:0]  mask;
  logic [NUM_SRC-1:0]  hw_set;
  logic [NUM_SRC-1:0]  sw_clr;
  logic [NUM_SRC-1:0]  sw_mask_wr;
  logic [NUM_SRC-1:0]  req;
  logic [NUM_SRC-1:0]  grant;
  logic [NUM_SRC-1:0]  higher_req;
  logic [2:0]          grant_idx;
  logic                any_grant;
  logic                ext0_rise;
  logic                ext1_rise;
  logic                take;
  logic                stop_cancel_seen;

  // ==========================================================================
  // External pins
  ext_edge_sync u_sync0 (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .pin_level  (ext_irq_in0),
    .rise_pulse (ext0_rise)
  );
  ext_edge_sync u_sync1 (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .pin_level  (ext_irq_in1),
    .rise_pulse (ext1_rise)
  );
  assign hw_set = {shift_done_event, conv_done_event, timer_c_event, timer_b_event,
                   timer_a_event, ext1_rise, ext0_rise};

  // ==========================================================================
  // Flags, masks and arbitration per source
  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      assign sw_clr[i]     = ctl_wr && ctl_addr == FLAG_WORD[i] && !ctl_wdata[FLAG_BIT[i]];
      assign sw_mask_wr[i] = ctl_wr && ctl_addr == FLAG_WORD[i];
      assign req[i]        = flag[i] & ~mask[i];
      if (i == 0) begin : g_top
        assign higher_req[i] = 1'b0;
      end else begin : g_low
        assign higher_req[i] = higher_req[i-1] | req[i-1];
      end
      assign grant[i] = global_irq_enable & req[i] & ~higher_req[i];
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          flag[i] <= FLAG_RESET[i];
          mask[i] <= MASK_RESET[i];
        end else begin
          // A hardware event in the clearing cycle wins over the clear.
          if (hw_set[i])
            flag[i] <= 1'b1;
          else if (sw_clr[i])
            flag[i] <= 1'b0;
          if (sw_mask_wr[i])
            mask[i] <= ctl_wdata[MASK_BIT[i]];
        end
      end
    end
  endgenerate

  assign any_grant = |grant;
  always_comb begin
    grant_idx = 3'h0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (grant[k])
        grant_idx = 3'(k);
    end
  end

  // ==========================================================================
  // Acknowledge sequence
  assign take = (seq == S_IDLE) && instr_boundary && any_grant && !stop_mode;
  always_comb begin
    next_seq = seq;
    unique case (seq)
      S_IDLE:   if (take) next_seq = S_FINISH;
      S_FINISH: next_seq = S_SAVE;
      S_SAVE:   next_seq = S_JUMP;
      S_JUMP:   next_seq = S_IDLE;
    endcase
  end
  assign irq_ack  = take;
  assign irq_push = (seq == S_SAVE) || (seq == S_JUMP);
  assign irq_jump = (seq == S_JUMP);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seq <= S_IDLE;
      irq_vector <= VEC_RESET;
    end else begin
      seq <= next_seq;
      // Stop-cancel restarts the core from address zero, just as the pin reset does.
      if (take)
        irq_vector <= VEC_BASE + 16'(grant_idx) * VEC_STEP;
      else if (stop_cancel_req)
        irq_vector <= VEC_RESET;
    end
  end

  // Enable is cleared in the second cycle; a return or write can reopen it in the save or jump cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      global_irq_enable <= IE_RESET;
    else if (seq == S_FINISH)
      global_irq_enable <= 1'b0;
    else if (return_from_irq_instr)
      global_irq_enable <= 1'b1;
    else if (ctl_wr && ctl_addr == ADDR_WORD0)
      global_irq_enable <= ctl_wdata[IE_BIT];
  end

  // ==========================================================================
  // Stop cancel and retained bits
  assign stop_cancel_req = stop_cancel_in & stop_mode;
  // Pin reset clears these; leaving stop through stop-cancel keeps bit 3 and marks RAM valid.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ram_valid_flag   <= 1'b0;
      portb_mode_bit3  <= 1'b0;
      stop_cancel_seen <= 1'b0;
    end else begin
      stop_cancel_seen <= stop_cancel_req;
      if (stop_cancel_req)
        ram_valid_flag <= 1'b1;
      if (portb_mode_bit3_wr)
        portb_mode_bit3 <= portb_mode_bit3_wdata;
    end
  end

  // ==========================================================================
  // Read-back
  always_comb begin
    unique case (ctl_addr)
      ADDR_WORD0: ctl_rdata = {mask[0], flag[0], 1'b0, global_irq_enable};
      ADDR_WORD1: ctl_rdata = {mask[2], flag[2], mask[1], flag[1]};
      ADDR_WORD2: ctl_rdata = {mask[4], flag[4], mask[3], flag[3]};
      ADDR_WORD3: ctl_rdata = {mask[6], flag[6], mask[5], flag[5]};
    endcase
  end

  // ==========================================================================
  // Checks
  a_grant_priority: assert property (@(posedge core_clk) disable iff (!nrst)
    take && req[0] |=> irq_vector == VEC_BASE) else $error("ext0 not chosen first");
  a_vector_range: assert property (@(posedge core_clk) disable iff (!nrst)
    irq_jump |-> irq_vector >= 16'h0002 && irq_vector <= 16'h000E) else $error("bad vector");
  a_stop_cancel_in_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    !stop_mode |-> !stop_cancel_req) else $error("stop cancel outside stop");
  a_take_needs_ie: assert property (@(posedge core_clk) disable iff (!nrst)
    take |-> global_irq_enable && (flag & ~mask) != 7'h00) else $error("take without cause");
  a_ie_cleared: assert property (@(posedge core_clk) disable iff (!nrst)
    take |-> ##2 !global_irq_enable) else $error("enable not cleared");
  a_flag_no_sw_set: assert property (@(posedge core_clk) disable iff (!nrst)
    !$past(flag[0]) && flag[0] |-> $past(ext0_rise)) else $error("flag set by software");
  a_ack_sequence: assert property (@(posedge core_clk) disable iff (!nrst)
    take |=> !irq_push ##1 irq_push && !irq_jump ##1 irq_push && irq_jump) else $error("seq");
  a_ram_valid: assert property (@(posedge core_clk) disable iff (!nrst)
    stop_cancel_req |=> ram_valid_flag) else $error("RAM-valid not set");
  a_stop_cancel_in_vector: assert property (@(posedge core_clk) disable iff (!nrst)
    stop_cancel_req |=> irq_vector == VEC_RESET) else $error("stop cancel vector not zero");
  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!nrst)
    hw_set[0] |=> flag[0]) else $error("hardware set lost");
  a_ie_return: assert property (@(posedge core_clk) disable iff (!nrst)
    return_from_irq_instr && seq != S_FINISH |=> global_irq_enable) else $error("enable not set");
  a_one_grant: assert property (@(posedge core_clk) disable iff (!nrst)
    $onehot0(grant)) else $error("more than one source granted");
  a_no_take_busy: assert property (@(posedge core_clk) disable iff (!nrst)
    seq != S_IDLE |-> !irq_ack) else $error("take during sequence");
  c_take_ext0: cover property (@(posedge core_clk) disable iff (!nrst) take && grant[0]);
  c_take_serial: cover property (@(posedge core_clk) disable iff (!nrst) take && grant[6]);
  c_stop_cancel: cover property (@(posedge core_clk) disable iff (!nrst) stop_cancel_seen);
  c_ie_return: cover property (@(posedge core_clk) disable iff (!nrst) return_from_irq_instr);
  c_hw_wins: cover property (@(posedge core_clk) disable iff (!nrst) hw_set[0] && sw_clr[0]);
endmodule
`default_nettype wire

// [sim/core_seq_model.sv]
// Behavioural stand-in for the core sequencer that faces the interrupt block.
// Assumes the bench asks for a return through ret_go, a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Sequencer handshake
  input  wire logic irq_push,
  input  wire logic ret_go,
  output logic      instr_boundary,
  output logic      return_from_irq_instr
);
  // ==========================================================================
  // Boundaries and returns
  // No instruction ends while state is being stacked, so no boundary then.
  assign instr_boundary = !irq_push;
  // The model holds no carry or working registers; software sets them up itself.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) return_from_irq_instr <= 1'b0;
    else return_from_irq_instr <= ret_go;
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the interrupt and reset control block.
// Assumes the design package and the core sequencer model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irq_ctrl_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, ctl_wr = 1'b0, ret_go = 1'b0;
  logic stop_mode = 1'b0, stop_cancel_in = 1'b0, pb_wr = 1'b0, pb_wd = 1'b0;
  logic [1:0] pins = 2'h0, ctl_addr = 2'h0;
  logic [4:0] evt = 5'h00;
  logic [3:0] ctl_wdata = 4'h0, ctl_rdata, rv;
  logic [15:0] irq_vector;
  logic instr_boundary, return_from_irq_instr, irq_ack, irq_push, irq_jump;
  logic stop_cancel_req, ram_valid_flag, portb_mode_bit3;
  int miscompares = 0, total_checks = 0;
  always #20 core_clk = ~core_clk;
  interrupt_reset_control interrupt_reset_control_inst (.core_clk(core_clk), .nrst(nrst),
    .ext_irq_in0(pins[0]), .ext_irq_in1(pins[1]), .stop_cancel_in(stop_cancel_in),
    .timer_a_event(evt[0]), .timer_b_event(evt[1]), .timer_c_event(evt[2]),
    .conv_done_event(evt[3]), .shift_done_event(evt[4]), .ctl_addr(ctl_addr),
    .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata),
    .instr_boundary(instr_boundary), .return_from_irq_instr(return_from_irq_instr),
    .stop_mode(stop_mode), .portb_mode_bit3_wr(pb_wr), .portb_mode_bit3_wdata(pb_wd),
    .irq_ack(irq_ack), .irq_push(irq_push), .irq_jump(irq_jump), .irq_vector(irq_vector),
    .stop_cancel_req(stop_cancel_req), .ram_valid_flag(ram_valid_flag),
    .portb_mode_bit3(portb_mode_bit3));
  core_seq_model core_seq_model_inst (.core_clk(core_clk), .nrst(nrst), .irq_push(irq_push),
    .ret_go(ret_go), .instr_boundary(instr_boundary),
    .return_from_irq_instr(return_from_irq_instr));
  // ==========================================================================
  // Shared tasks
  task automatic final_report;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [3:0] d);
    @(posedge core_clk);
    ctl_addr <= a; ctl_wr <= 1'b1; ctl_wdata <= d;
    @(posedge core_clk);
    ctl_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [3:0] d);
    @(posedge core_clk);
    ctl_addr <= a;
    #1;
    d = ctl_rdata;
  endtask
  // Pins idle low so that reset release never looks like a rising edge.
  task automatic raise(input int i);
    @(posedge core_clk);
    if (i < 2) pins[i] <= 1'b1; else evt[i-2] <= 1'b1;
    @(posedge core_clk);
    if (i < 2) pins[i] <= 1'b0; else evt[i-2] <= 1'b0;
    step(4);
  endtask
  task automatic take_walk(input logic [15:0] exp);
    int n;
    #1;
    for (n = 0; n < 50 && irq_ack !== 1'b1; n++) step(1);
    if (n == 50) begin miscompares++; final_report(); end
    step(1); chk(irq_vector, exp);
    step(1); chk({irq_push, irq_jump}, 2'b10);
    step(1); chk({irq_push, irq_jump}, 2'b11);
    rd(ADDR_WORD0, rv); chk(rv[0], 1'b0);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd(ADDR_WORD0, rv); chk(rv, 4'h8);
    for (int w = 1; w < 4; w++) begin
      rd(w[1:0], rv); chk(rv, 4'hA);
    end
    chk(irq_vector, VEC_RESET);
    chk({ram_valid_flag, portb_mode_bit3}, 2'b00);
  endtask
  task automatic t_no_set;
    for (int w = 1; w < 4; w++) wr(w[1:0], 4'h5);
    wr(ADDR_WORD0, 4'h4);
    for (int w = 0; w < 4; w++) begin
      rd(w[1:0], rv); chk(rv, 4'h0);
    end
  endtask
  // All seven pending at once: takes must come strictly in priority order.
  task automatic t_priority;
    for (int i = 0; i < NUM_SRC; i++) raise(i);
    rd(ADDR_WORD1, rv); chk(rv, 4'h5);
    chk(irq_ack, 1'b0);
    wr(ADDR_WORD0, 4'h5);
    for (int i = 0; i < NUM_SRC; i++) begin
      take_walk(16'h0002 + 16'(2 * i));
      wr(FLAG_WORD[i], (FLAG_WORD[i] == 2'h0 ? 4'h4 : 4'h5) & ~(4'h1 << FLAG_BIT[i]));
      @(posedge core_clk); ret_go <= 1'b1;
      @(posedge core_clk); ret_go <= 1'b0;
    end
    rd(ADDR_WORD0, rv); chk(rv, 4'h1);
  endtask
  task automatic t_mask;
    wr(ADDR_WORD1, 4'h7);
    raise(1);
    chk(irq_ack, 1'b0);
    @(posedge core_clk); evt[2] <= 1'b1;
    @(posedge core_clk); evt[2] <= 1'b0;
    take_walk(16'h000A);
    rd(ADDR_WORD1, rv); chk(rv, 4'h3);
  endtask
  task automatic t_stop;
    @(posedge core_clk); pb_wr <= 1'b1; pb_wd <= 1'b1; stop_cancel_in <= 1'b1;
    @(posedge core_clk); pb_wr <= 1'b0;
    step(2); chk({stop_cancel_req, ram_valid_flag, portb_mode_bit3}, 3'b001);
    @(posedge core_clk); stop_mode <= 1'b1;
    step(2); chk({stop_cancel_req, ram_valid_flag, portb_mode_bit3}, 3'b111);
    chk(irq_vector, VEC_RESET);
    @(posedge core_clk); stop_mode <= 1'b0; stop_cancel_in <= 1'b0; nrst <= 1'b0;
    step(2); nrst <= 1'b1;
    step(1); chk({ram_valid_flag, portb_mode_bit3}, 2'b00);
    rd(ADDR_WORD0, rv); chk(rv, 4'h8);
  endtask
  initial begin
    step(16);
    nrst <= 1'b1;
    step(1);
    t_reset();
    t_no_set();
    t_priority();
    t_mask();
    t_stop();
    final_report();
  end
endmodule
`default_nettype wire
